// File: design/queue_congestion_threshold_pkg.sv
// Constants, types and carriers for the congestion threshold bank
package queue_congestion_threshold_pkg;
    localparam int PORTS = 15;
    localparam int PRIOS = 8;
    localparam int PORT_W = 4;
    localparam int PRIO_W = 3;
    localparam int DP_W = 2;
    localparam int THR_W = 16;
    localparam int IDX_W = 13;
    localparam int SLOT_W = 10;
    localparam int CNT_W = 32;
    // Table layout inside each 1,024 entry block
    localparam int BLK_SHIFT = 10;
    localparam int BLK_COUNT = 5;
    localparam int RSV_LAST = 119;
    localparam int SHPRIO_BASE = 496;
    localparam int SHPRIO_LAST = 503;
    localparam int SHDP_BASE = 508;
    localparam int SHDP_LAST = 511;
    localparam int PORTSH_BASE = 512;
    localparam int PORTSH_LAST = 526;
    // Compacted slot layout, only documented entries get storage
    localparam int LOC_SHPRIO = 120;
    localparam int LOC_SHDP = 128;
    localparam int LOC_PORTSH = 132;
    localparam int BLK_SLOTS = 147;
    localparam int SLOTS = BLK_SLOTS * BLK_COUNT;
    localparam logic [2:0] BLK_IGR_MEM = 3'h0;
    localparam logic [2:0] BLK_IGR_REF = 3'h1;
    localparam logic [2:0] BLK_EGR_MEM = 3'h2;
    localparam logic [2:0] BLK_EGR_REF = 3'h3;
    localparam logic [2:0] BLK_PFC = 3'h4;
    localparam int PROFILES = 72;
    localparam int PROF_W = 7;
    localparam int PROF_PER_GRP = 24;
    localparam logic [1:0] GRP_NONE = 2'h3;
    localparam logic [1:0] DP_GREEN = 2'h0;
    localparam logic [1:0] DP_ONE = 2'h1;
    localparam logic [THR_W-1:0] THR_RST = 16'hffff;
    localparam logic [1:0] WRED_PASS = 2'h0;
    localparam logic [1:0] WRED_RAMP = 2'h1;
    localparam logic [1:0] WRED_FULL = 2'h2;

    typedef enum logic [1:0] {VIEW_THR, VIEW_HIGH, VIEW_CUR} view_t;

    typedef struct packed {
        logic vld;
        logic [IDX_W-1:0] idx;
        logic [THR_W-1:0] val;
    } entry_wr_t;

    typedef struct packed {
        logic vld;
        logic [PROF_W-1:0] idx;
        logic [THR_W-1:0] lo;
        logic [THR_W-1:0] hi;
    } prof_wr_t;

    typedef struct packed {
        logic vld;
        logic [PORT_W-1:0] port;
        logic [PRIO_W-1:0] prio;
        logic [DP_W-1:0] dp;
        logic [THR_W-1:0] fill;
    } query_t;

    typedef struct packed {
        logic vld;
        logic [SLOT_W-1:0] slot;
    } slot_t;
endpackage

// File: design/queue_congestion_threshold_bank.sv
// Threshold table, status views, discard profiles and forwarder monitors
// Behaviour
// - Flow-control account on ingress memory requests pause, never drops copies
// - Flow-control account uses the same threshold set and layout
// - Ingress reservation for port P priority Q at index 8P+Q
// - Shared ingress priority threshold at index 496+Q
// - Drop level thresholds at 508 to 511, ordered 1,2,3,0
// - Per-port shared reservation at index 512+P
// - Ingress reference thresholds mirror layout at offset 1,024
// - Egress memory thresholds mirror layout at offset 2,048
// - Egress reference thresholds mirror layout at offset 3,072
// - Pause thresholds at offset 4,096; pause when no memory remains
// - High-water view returns largest value compared with each threshold
// - Current view returns value presently compared with each threshold
// - 72 discard profiles: three groups, three drop levels, eight priorities
// - Per-port discard group assignment and per-port pause enable
// - Per-class enables turn on reserved shared memory
// - Per-port yellow-in-reserved and shared-space block controls
// - Sticky per-port drop bit holds until software clears it
// - Count frames not forwarded to processor due to congestion
// - Count every frame copy added to any egress queue
// - One global counter of copies discarded by forward pressure
// - Report present ingress queue size
// - Report free frame references for egress queues
// - Drop level zero is green, never subject to a profile
`timescale 1ns/1ps
module queue_congestion_threshold_bank #(
    parameter int CNT_W = queue_congestion_threshold_pkg::CNT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Table and profile configuration
    input wire queue_congestion_threshold_pkg::entry_wr_t threshold_table_entry,
    input wire queue_congestion_threshold_pkg::prof_wr_t early_discard_profile,
    // Table read port
    input wire logic [queue_congestion_threshold_pkg::IDX_W-1:0] rd_idx,
    input wire queue_congestion_threshold_pkg::view_t rd_view,
    output logic [queue_congestion_threshold_pkg::THR_W-1:0] rd_data_r,
    // Per-port and per-class controls
    input wire logic [2*queue_congestion_threshold_pkg::PORTS-1:0] early_discard_group_assign,
    input wire logic [queue_congestion_threshold_pkg::PORTS-1:0] flow_control_port_enable,
    input wire logic [queue_congestion_threshold_pkg::PRIOS-1:0] class_reservation_enable,
    input wire logic [queue_congestion_threshold_pkg::PORTS-1:0] yellow_may_use_reserved,
    input wire logic [queue_congestion_threshold_pkg::PORTS-1:0] ingress_shared_block,
    input wire logic [queue_congestion_threshold_pkg::PORTS-1:0] egress_shared_block,
    // Accounting engine: value now compared with an entry
    input wire queue_congestion_threshold_pkg::entry_wr_t acct_update,
    // Admission and discard queries
    input wire queue_congestion_threshold_pkg::query_t admit_query,
    input wire queue_congestion_threshold_pkg::query_t discard_query,
    output logic admit_vld_r,
    output logic admit_drop_r,
    output logic discard_vld_r,
    output logic [1:0] discard_level_r,
    // Pause requests, one per port and priority
    output logic [queue_congestion_threshold_pkg::PORTS*queue_congestion_threshold_pkg::PRIOS-1:0]
        pause_req_r,
    // Forwarder events and monitors
    input wire logic [queue_congestion_threshold_pkg::PORTS-1:0] port_drop_evt,
    input wire logic [queue_congestion_threshold_pkg::PORTS-1:0] sticky_clr,
    input wire logic cpu_drop_evt,
    input wire logic enqueue_evt,
    input wire logic pressure_drop_evt,
    output logic [queue_congestion_threshold_pkg::PORTS-1:0] ingress_drop_sticky_bits_r,
    output logic [CNT_W-1:0] processor_drop_counter_r,
    output logic [CNT_W-1:0] enqueued_copy_counter_r,
    output logic [CNT_W-1:0] pressure_discard_counter_r,
    // Queue system status
    input wire logic [queue_congestion_threshold_pkg::THR_W-1:0] iq_size_in,
    input wire logic [queue_congestion_threshold_pkg::THR_W-1:0] free_ref_in,
    output logic [queue_congestion_threshold_pkg::THR_W-1:0] ingress_queue_size_status_r,
    output logic [queue_congestion_threshold_pkg::THR_W-1:0] free_reference_status_r
);
    localparam int TW = queue_congestion_threshold_pkg::THR_W;
    localparam int SL = queue_congestion_threshold_pkg::SLOTS;
    localparam int NP = queue_congestion_threshold_pkg::PROFILES;
    localparam int NQ = queue_congestion_threshold_pkg::PORTS * queue_congestion_threshold_pkg::PRIOS;
    localparam int SW = queue_congestion_threshold_pkg::SLOT_W;

    typedef struct packed {
        logic [SL-1:0][TW-1:0] thr;
        logic [SL-1:0][TW-1:0] high;
        logic [SL-1:0][TW-1:0] cur;
        logic [NP-1:0][TW-1:0] prof_lo;
        logic [NP-1:0][TW-1:0] prof_hi;
        logic [TW-1:0] rd_data;
        logic admit_vld;
        logic admit_drop;
        logic discard_vld;
        logic [1:0] discard_level;
        logic [NQ-1:0] pause;
        logic [queue_congestion_threshold_pkg::PORTS-1:0] sticky;
        logic [CNT_W-1:0] cpu_cnt;
        logic [CNT_W-1:0] enq_cnt;
        logic [CNT_W-1:0] press_cnt;
        logic [TW-1:0] iq_size;
        logic [TW-1:0] free_ref;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // Compacts a table index to a storage slot; gaps get no storage
    function automatic queue_congestion_threshold_pkg::slot_t slot_of(
        input logic [queue_congestion_threshold_pkg::IDX_W-1:0] idx
    );
        queue_congestion_threshold_pkg::slot_t r;
        int blk;
        int off;
        int loc;
        blk = int'(idx >> queue_congestion_threshold_pkg::BLK_SHIFT);
        off = int'(idx) - (blk << queue_congestion_threshold_pkg::BLK_SHIFT);
        r.vld = 1'b1;
        loc = 0;
        if (off <= queue_congestion_threshold_pkg::RSV_LAST) begin
            loc = off;
        end else if (off >= queue_congestion_threshold_pkg::SHPRIO_BASE &&
                off <= queue_congestion_threshold_pkg::SHPRIO_LAST) begin
            loc = queue_congestion_threshold_pkg::LOC_SHPRIO + off -
                queue_congestion_threshold_pkg::SHPRIO_BASE;
        end else if (off >= queue_congestion_threshold_pkg::SHDP_BASE &&
                off <= queue_congestion_threshold_pkg::SHDP_LAST) begin
            loc = queue_congestion_threshold_pkg::LOC_SHDP + off -
                queue_congestion_threshold_pkg::SHDP_BASE;
        end else if (off >= queue_congestion_threshold_pkg::PORTSH_BASE &&
                off <= queue_congestion_threshold_pkg::PORTSH_LAST) begin
            loc = queue_congestion_threshold_pkg::LOC_PORTSH + off -
                queue_congestion_threshold_pkg::PORTSH_BASE;
        end else begin
            r.vld = 1'b0;
        end
        if (blk >= queue_congestion_threshold_pkg::BLK_COUNT) begin
            r.vld = 1'b0;
        end
        r.slot = SW'(blk * queue_congestion_threshold_pkg::BLK_SLOTS + loc);
        return r;
    endfunction

    // Slot of a local entry within a given block
    function automatic logic [SW-1:0] slot_in(input logic [2:0] blk, input int loc);
        return SW'(int'(blk) * queue_congestion_threshold_pkg::BLK_SLOTS + loc);
    endfunction

    function automatic logic room(input state_t s, input logic [SW-1:0] sl);
        return s.cur[sl] < s.thr[sl];
    endfunction

    always_comb begin
        queue_congestion_threshold_pkg::slot_t ws;
        queue_congestion_threshold_pkg::slot_t us;
        queue_congestion_threshold_pkg::slot_t rs;
        logic [SW-1:0] s_rsv;
        logic [SW-1:0] s_psh;
        logic [SW-1:0] s_cls;
        logic [SW-1:0] s_dp;
        logic [SW-1:0] e_rsv;
        logic [SW-1:0] e_dp;
        logic rsv_ok;
        logic shr_ok;
        logic egr_ok;
        logic drop;
        logic [1:0] grp;
        logic [queue_congestion_threshold_pkg::PROF_W-1:0] pidx;
        int ap;
        int aq;
        int pq;
        int upd_off;
        s_nxt = s_r;
        ws = slot_of(threshold_table_entry.idx);
        us = slot_of(acct_update.idx);
        rs = slot_of(rd_idx);
        ap = int'(admit_query.port);
        aq = int'(admit_query.prio);
        drop = 1'b0;
        upd_off = int'(acct_update.idx) -
            (int'(queue_congestion_threshold_pkg::BLK_PFC) <<
            queue_congestion_threshold_pkg::BLK_SHIFT);
        pq = upd_off / queue_congestion_threshold_pkg::PRIOS;

        // writes to unused indexes fall away
        if (threshold_table_entry.vld && ws.vld) begin
            s_nxt.thr[ws.slot] = threshold_table_entry.val;
        end

        if (early_discard_profile.vld && int'(early_discard_profile.idx) < NP) begin
            s_nxt.prof_lo[early_discard_profile.idx] = early_discard_profile.lo;
            s_nxt.prof_hi[early_discard_profile.idx] = early_discard_profile.hi;
        end

        if (acct_update.vld && us.vld) begin
            s_nxt.cur[us.slot] = acct_update.val;
            if (acct_update.val > s_r.high[us.slot]) begin
                s_nxt.high[us.slot] = acct_update.val;
            end
            // pause from the ingress-memory based account
            if (upd_off >= 0 && upd_off <= queue_congestion_threshold_pkg::RSV_LAST &&
                    upd_off < NQ) begin
                s_nxt.pause[upd_off] = flow_control_port_enable[pq] &&
                    acct_update.val >= s_r.thr[us.slot];
            end
        end

        // status views read with the same indexing
        s_nxt.rd_data = '0;
        if (rs.vld) begin
            unique case (rd_view)
                queue_congestion_threshold_pkg::VIEW_THR: s_nxt.rd_data = s_r.thr[rs.slot];
                queue_congestion_threshold_pkg::VIEW_HIGH: s_nxt.rd_data = s_r.high[rs.slot];
                queue_congestion_threshold_pkg::VIEW_CUR: s_nxt.rd_data = s_r.cur[rs.slot];
                default: s_nxt.rd_data = '0;
            endcase
        end

        // Admission on ingress and egress memory; the pause block is never read here
        s_rsv = slot_in(queue_congestion_threshold_pkg::BLK_IGR_MEM,
            ap * queue_congestion_threshold_pkg::PRIOS + aq);
        s_psh = slot_in(queue_congestion_threshold_pkg::BLK_IGR_MEM,
            queue_congestion_threshold_pkg::LOC_PORTSH + ap);
        s_cls = slot_in(queue_congestion_threshold_pkg::BLK_IGR_MEM,
            queue_congestion_threshold_pkg::LOC_SHPRIO + aq);
        // drop level 1 first, level 0 last
        s_dp = slot_in(queue_congestion_threshold_pkg::BLK_IGR_MEM,
            queue_congestion_threshold_pkg::LOC_SHDP +
            int'(2'(admit_query.dp - queue_congestion_threshold_pkg::DP_ONE)));
        e_rsv = slot_in(queue_congestion_threshold_pkg::BLK_EGR_MEM,
            ap * queue_congestion_threshold_pkg::PRIOS + aq);
        e_dp = slot_in(queue_congestion_threshold_pkg::BLK_EGR_MEM,
            queue_congestion_threshold_pkg::LOC_SHDP +
            int'(2'(admit_query.dp - queue_congestion_threshold_pkg::DP_ONE)));
        // yellow may be kept out of reserved space
        rsv_ok = (room(s_r, s_rsv) || room(s_r, s_psh)) &&
            (admit_query.dp == queue_congestion_threshold_pkg::DP_GREEN ||
            yellow_may_use_reserved[ap]);
        // class reservation and ingress sharing block
        shr_ok = !ingress_shared_block[ap] && room(s_r, s_dp) &&
            (!class_reservation_enable[aq] || room(s_r, s_cls));
        egr_ok = room(s_r, e_rsv) || (!egress_shared_block[ap] && room(s_r, e_dp));
        s_nxt.admit_vld = admit_query.vld;
        s_nxt.admit_drop = 1'b0;
        if (admit_query.vld && ap < queue_congestion_threshold_pkg::PORTS) begin
            drop = !((rsv_ok || shr_ok) && egr_ok);
            s_nxt.admit_drop = drop;
        end

        // group of the querying port selects the profile set
        grp = early_discard_group_assign[2*int'(discard_query.port) +: 2];
        pidx = queue_congestion_threshold_pkg::PROF_W'(
            int'(grp) * queue_congestion_threshold_pkg::PROF_PER_GRP +
            int'(2'(discard_query.dp - queue_congestion_threshold_pkg::DP_ONE)) *
            queue_congestion_threshold_pkg::PRIOS + int'(discard_query.prio));
        s_nxt.discard_vld = discard_query.vld;
        s_nxt.discard_level = queue_congestion_threshold_pkg::WRED_PASS;
        if (discard_query.vld && grp != queue_congestion_threshold_pkg::GRP_NONE &&
                discard_query.dp != queue_congestion_threshold_pkg::DP_GREEN &&
                int'(discard_query.port) < queue_congestion_threshold_pkg::PORTS) begin
            if (discard_query.fill >= s_r.prof_hi[pidx]) begin
                s_nxt.discard_level = queue_congestion_threshold_pkg::WRED_FULL;
            end else if (discard_query.fill >= s_r.prof_lo[pidx]) begin
                s_nxt.discard_level = queue_congestion_threshold_pkg::WRED_RAMP;
            end
        end

        // sticky drop bits, a new drop beats a clear
        s_nxt.sticky = (s_r.sticky & ~sticky_clr) | port_drop_evt;
        if (drop) begin
            s_nxt.sticky[ap] = 1'b1;
        end

        if (cpu_drop_evt) begin
            s_nxt.cpu_cnt = s_r.cpu_cnt + CNT_W'(1);
        end
        if (enqueue_evt) begin
            s_nxt.enq_cnt = s_r.enq_cnt + CNT_W'(1);
        end
        if (pressure_drop_evt) begin
            s_nxt.press_cnt = s_r.press_cnt + CNT_W'(1);
        end
        s_nxt.iq_size = iq_size_in;
        s_nxt.free_ref = free_ref_in;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_r <= '0;
            // Open thresholds so nothing drops before software configures
            s_r.thr <= {SL{queue_congestion_threshold_pkg::THR_RST}};
            s_r.prof_lo <= {NP{queue_congestion_threshold_pkg::THR_RST}};
            s_r.prof_hi <= {NP{queue_congestion_threshold_pkg::THR_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data_r = s_r.rd_data;
    assign admit_vld_r = s_r.admit_vld;
    assign admit_drop_r = s_r.admit_drop;
    assign discard_vld_r = s_r.discard_vld;
    assign discard_level_r = s_r.discard_level;
    assign pause_req_r = s_r.pause;
    assign ingress_drop_sticky_bits_r = s_r.sticky;
    assign processor_drop_counter_r = s_r.cpu_cnt;
    assign enqueued_copy_counter_r = s_r.enq_cnt;
    assign pressure_discard_counter_r = s_r.press_cnt;
    assign ingress_queue_size_status_r = s_r.iq_size;
    assign free_reference_status_r = s_r.free_ref;
endmodule

// File: dv/queue_congestion_threshold_checker.sv
// Port-level assertions for the congestion threshold bank
`timescale 1ns/1ps
module queue_congestion_threshold_checker #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Table and queries
    input wire logic [12:0] rd_idx,
    input wire logic [15:0] rd_data_r,
    input wire queue_congestion_threshold_pkg::entry_wr_t acct_update,
    input wire queue_congestion_threshold_pkg::query_t discard_query,
    input wire logic discard_vld_r,
    input wire logic [1:0] discard_level_r,
    input wire logic [119:0] pause_req_r,
    // Forwarder events and monitors
    input wire logic [14:0] port_drop_evt,
    input wire logic [14:0] sticky_clr,
    input wire logic cpu_drop_evt,
    input wire logic enqueue_evt,
    input wire logic pressure_drop_evt,
    input wire logic [14:0] ingress_drop_sticky_bits_r,
    input wire logic [CNT_W-1:0] processor_drop_counter_r,
    input wire logic [CNT_W-1:0] enqueued_copy_counter_r,
    input wire logic [CNT_W-1:0] pressure_discard_counter_r,
    // Status
    input wire logic [15:0] iq_size_in,
    input wire logic [15:0] free_ref_in,
    input wire logic [15:0] ingress_queue_size_status_r,
    input wire logic [15:0] free_reference_status_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_unused_rd; rd_idx >= 13'h1400 |=> rd_data_r == 16'h0000; endproperty
    a_unused_rd: assert property (p_unused_rd) else $error("Unused index read nonzero");
    property p_enq; 1 |=> enqueued_copy_counter_r ==
        $past(enqueued_copy_counter_r) + CNT_W'($past(enqueue_evt)); endproperty
    a_enq: assert property (p_enq) else $error("Enqueue counter step wrong");
    property p_cpu; cpu_drop_evt |=>
        processor_drop_counter_r == $past(processor_drop_counter_r) + 1'b1; endproperty
    a_cpu: assert property (p_cpu) else $error("Processor drop count missed");
    property p_press; !pressure_drop_evt |=> $stable(pressure_discard_counter_r); endproperty
    a_press: assert property (p_press) else $error("Pressure counter moved idle");
    property p_stk_set; port_drop_evt != 15'h0000 |=>
        (ingress_drop_sticky_bits_r & $past(port_drop_evt)) == $past(port_drop_evt); endproperty
    a_stk_set: assert property (p_stk_set) else $error("Drop did not set sticky");
    property p_stk_hold; sticky_clr == 15'h0000 |=> (ingress_drop_sticky_bits_r &
        $past(ingress_drop_sticky_bits_r)) == $past(ingress_drop_sticky_bits_r); endproperty
    a_stk_hold: assert property (p_stk_hold) else $error("Sticky bit lost");
    property p_iq; 1 |=> ingress_queue_size_status_r == $past(iq_size_in); endproperty
    a_iq: assert property (p_iq) else $error("Queue size status wrong");
    property p_free; 1 |=> free_reference_status_r == $past(free_ref_in); endproperty
    a_free: assert property (p_free) else $error("Free reference status wrong");
    property p_green; discard_query.vld && discard_query.dp == 2'h0 |=>
        discard_vld_r && discard_level_r == 2'h0; endproperty
    a_green: assert property (p_green) else $error("Green frame got discard level");
    property p_pause; !acct_update.vld |=> $stable(pause_req_r); endproperty
    a_pause: assert property (p_pause) else $error("Pause moved without update");
    c_pause: cover property (pause_req_r != 120'h0);
    c_full: cover property (discard_vld_r && discard_level_r == 2'h2);
    c_drop: cover property (port_drop_evt != 15'h0000 && sticky_clr != 15'h0000);
endmodule
bind queue_congestion_threshold_bank queue_congestion_threshold_checker #(.CNT_W(CNT_W)) chk (.*);

// File: dv/queue_congestion_threshold_bank_test.sv
// Self-checking random testbench for the congestion threshold bank
`timescale 1ns/1ps
module queue_congestion_threshold_bank_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    queue_congestion_threshold_pkg::entry_wr_t wr_s = '0, acct_s = '0;
    queue_congestion_threshold_pkg::prof_wr_t prof_s = '0;
    queue_congestion_threshold_pkg::query_t adm_s = '0, dis_s = '0;
    queue_congestion_threshold_pkg::view_t rd_view = queue_congestion_threshold_pkg::VIEW_THR;
    logic [12:0] rd_idx = '0;
    logic [15:0] rd_data, iq_in = '0, fr_in = '0, iq_q, fr_q, v, lo;
    logic [29:0] grp_a = '1;
    logic [14:0] pfc_en = '0, yel = '1, igr_blk = '0, egr_blk = '0, drop_evt = '0, clr = '0;
    logic [14:0] sticky, stk;
    logic [7:0] cls_en = '0;
    logic cpu_e = 1'b0, enq_e = 1'b0, prs_e = 1'b0, adm_v, adm_d, dis_v;
    logic [1:0] dis_l;
    logic [119:0] pause;
    logic [31:0] c_cpu, c_enq, c_prs, e_cpu = '0, e_enq = '0, e_prs = '0;
    int err_count = 0, tests_run = 0, p, q, d, s, b, i, offs[4];
    queue_congestion_threshold_bank dut (.clock(clock), .sys_rst(sys_rst),
        .threshold_table_entry(wr_s), .early_discard_profile(prof_s), .rd_idx(rd_idx),
        .rd_view(rd_view), .rd_data_r(rd_data), .early_discard_group_assign(grp_a),
        .flow_control_port_enable(pfc_en), .class_reservation_enable(cls_en),
        .yellow_may_use_reserved(yel), .ingress_shared_block(igr_blk),
        .egress_shared_block(egr_blk), .acct_update(acct_s), .admit_query(adm_s),
        .discard_query(dis_s), .admit_vld_r(adm_v), .admit_drop_r(adm_d),
        .discard_vld_r(dis_v), .discard_level_r(dis_l), .pause_req_r(pause),
        .port_drop_evt(drop_evt), .sticky_clr(clr), .cpu_drop_evt(cpu_e), .enqueue_evt(enq_e),
        .pressure_drop_evt(prs_e), .ingress_drop_sticky_bits_r(sticky),
        .processor_drop_counter_r(c_cpu), .enqueued_copy_counter_r(c_enq),
        .pressure_discard_counter_r(c_prs), .iq_size_in(iq_in), .free_ref_in(fr_in),
        .ingress_queue_size_status_r(iq_q), .free_reference_status_r(fr_q));
    always #2.5 clock = ~clock;
    task automatic tick(int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic put(ref queue_congestion_threshold_pkg::entry_wr_t sg, input int idx,
        input logic [15:0] val);
        sg = '{1'b1, 13'(idx), val};
        tick();
        sg.vld = 1'b0;
        tick();
    endtask
    task automatic rd(int idx, int vw, logic [15:0] exp);
        rd_idx = 13'(idx);
        rd_view = queue_congestion_threshold_pkg::view_t'(vw);
        tick(2);
        check(32'(rd_data), 32'(exp));
    endtask
    task automatic admit(int dp, logic exp);
        adm_s = '{1'b1, 4'(p), 3'(q), 2'(dp), 16'h0000};
        tick();
        adm_s.vld = 1'b0;
        check(32'(adm_v), 32'h0000_0001);
        check(32'(adm_d), 32'(exp));
        tick();
    endtask
    function automatic logic [1:0] lvl(logic [15:0] f, logic [15:0] l, int dp, int g);
        if (dp == 0 || g == 3) return 2'h0;
        return (f >= l + 16'h0004) ? 2'h2 : (f >= l) ? 2'h1 : 2'h0;
    endfunction
    task automatic disc(int dp, int g, logic [15:0] f, logic [15:0] l);
        dis_s = '{1'b1, 4'(p), 3'(q), 2'(dp), f};
        tick();
        check(32'(dis_v), 32'h0000_0001);
        check(32'(dis_l), 32'(lvl(f, l, dp, g)));
    endtask
    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h97916e50));
        cls_en = 8'($urandom);
        igr_blk = 15'($urandom);
        tick(3);
        sys_rst = 1'b0;
        for (b = 0; b < 5; b++) begin
            rd(b * 1024 + 119, 0, 16'hffff);
            rd(b * 1024 + 526, 1, 16'h0000);
        end
        check(32'(|pause), 32'h0000_0000);
        $display("Test reset done");
        for (b = 0; b < 5; b++) begin
            p = $urandom_range(14);
            q = $urandom_range(7);
            offs = '{8 * p + q, 496 + q, 508 + $urandom_range(3), 512 + p};
            for (s = 0; s < 4; s++) begin
                v = 16'($urandom) | 16'h0001;
                put(wr_s, b * 1024 + offs[s], v);
                rd(b * 1024 + offs[s], 0, v);
            end
            i = b * 1024 + 120 + $urandom_range(375);
            put(wr_s, i, 16'h1234);
            rd(i, 0, 16'h0000);
        end
        rd(5120 + $urandom_range(3071), 0, 16'h0000);
        $display("Test layout done");
        i = 3072 + 8 * $urandom_range(14) + $urandom_range(7);
        v = 16'($urandom) | 16'h8000;
        put(acct_s, i, v);
        put(acct_s, i, v >> 1);
        rd(i, 1, v);
        rd(i, 2, v >> 1);
        rd(i, 3, 16'h0000);
        $display("Test views done");
        p = $urandom_range(14);
        q = $urandom_range(7);
        pfc_en = 15'h0001 << p;
        put(wr_s, 4096 + 8 * p + q, 16'h0400);
        put(acct_s, 4096 + 8 * p + q, 16'h03ff);
        tick(2);
        check(32'(pause[8*p+q]), 32'h0000_0000);
        put(acct_s, 4096 + 8 * p + q, 16'h0400);
        tick(2);
        check(32'(pause[8*p+q]), 32'h0000_0001);
        admit(0, 1'b0);
        pfc_en = '0;
        put(acct_s, 4096 + 8 * p + q, 16'h0400);
        tick(2);
        check(32'(pause[8*p+q]), 32'h0000_0000);
        $display("Test pause done");
        put(wr_s, 2048 + 8 * p + q, 16'h0000);
        for (d = 0; d < 4; d++) begin
            for (s = 0; s < 4; s++) begin
                put(wr_s, 2556 + s, (s == (d + 3) % 4) ? 16'hffff : 16'h0000);
            end
            admit(d, 1'b0);
        end
        egr_blk = 15'h0001 << p;
        admit(1, 1'b1);
        check(32'(sticky[p]), 32'h0000_0001);
        clr = 15'h0001 << p;
        tick();
        check(32'(sticky[p]), 32'h0000_0000);
        drop_evt = clr;
        tick();
        {drop_evt, clr} = '0;
        check(32'(sticky[p]), 32'h0000_0001);
        {yel, igr_blk, egr_blk, cls_en} = '0;
        put(wr_s, 496 + q, 16'h0000);
        admit(3, 1'b0);
        cls_en[q] = 1'b1;
        admit(3, 1'b1);
        $display("Test admission done");
        p = $urandom_range(14);
        for (i = 0; i < 72; i++) begin
            prof_s = '{1'b1, 7'(i), 16'(i * 16 + 64), 16'(i * 16 + 68)};
            tick();
        end
        prof_s.vld = 1'b0;
        for (i = 0; i < 72; i++) begin
            grp_a = ~(30'h0000_0003 << (2 * p)) | (30'(i / 24) << (2 * p));
            q = i % 8;
            lo = 16'(i * 16 + 64);
            disc((i / 8) % 3 + 1, i / 24, lo - 16'h0002, lo);
            disc((i / 8) % 3 + 1, i / 24, lo + 16'h0002, lo);
            disc((i / 8) % 3 + 1, i / 24, lo + 16'h0004, lo);
            disc(0, i / 24, lo + 16'h0009, lo);
        end
        grp_a = '1;
        disc(2, 3, 16'hfff0, 16'h0040);
        dis_s.vld = 1'b0;
        $display("Test discard done");
        stk = sticky;
        for (s = 0; s < 300; s++) begin
            {cpu_e, enq_e, prs_e} = 3'($urandom);
            drop_evt = 15'($urandom & $urandom);
            clr = 15'($urandom);
            iq_in = 16'($urandom);
            fr_in = 16'($urandom);
            e_cpu += 32'(cpu_e);
            e_enq += 32'(enq_e);
            e_prs += 32'(prs_e);
            stk = (stk & ~clr) | drop_evt;
            tick();
            check(c_cpu, e_cpu);
            check(c_enq, e_enq);
            check(c_prs, e_prs);
            check(32'(sticky), 32'(stk));
            check(32'(iq_q), 32'(iq_in));
            check(32'(fr_q), 32'(fr_in));
        end
        {cpu_e, enq_e, prs_e, drop_evt, clr} = '0;
        $display("Test monitors done");
        complete_run();
    end
endmodule
